// ---- bench/epiv_cpu_model.sv ----
// Behavioural core: instruction boundaries and return from service
`timescale 1ns/1ps
`default_nettype none
module epiv_cpu_model
(
   input  wire logic pclk,           // Bus clock
   input  wire logic presetn,        // Async reset, active low
   input  wire logic slow,           // Long instructions
   input  wire logic vec_taken,      // Entry complete
   output logic      cpu_insn_done,  // Boundary pulse
   output logic      cpu_mask_load,  // Return restores mask
   output logic      cpu_mask_value  // Restored mask value
);
   logic [3:0] insn_cnt;
   logic [5:0] isr_cnt;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         insn_cnt      <= 4'h0;
         cpu_insn_done <= 1'b0;
      end
      else
      begin
         insn_cnt      <= (insn_cnt >= (slow ? 4'h9 : 4'h1)) ? 4'h0 : insn_cnt + 4'h1;
         cpu_insn_done <= (insn_cnt == 4'h0);
      end

   // Service routine length leaves room for the flag clear
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         isr_cnt <= 6'h00;
      else
         isr_cnt <= vec_taken ? 6'h28 : (isr_cnt != 6'h00) ? isr_cnt - 6'h01 : 6'h00;
   assign cpu_mask_load  = (isr_cnt == 6'h01);
   assign cpu_mask_value = 1'b0; // Stacked mask was clear
endmodule
`default_nettype wire

// ---- bench/epiv_top_properties.sv ----
// Concurrent checks on the pin interrupt and vector sequencer ports
`timescale 1ns/1ps
`default_nettype none
module epiv_top_properties
   import epiv_pkg::*;
(
   input wire logic        pclk,             // Bus clock
   input wire logic        presetn,          // Async reset, active low
   input wire logic        stop_mode,        // Clocks stopped
   input wire logic        wake_async,       // Wake request
   input wire logic        pull_enable,      // Internal pull on
   input wire logic        branch_pin_valid, // Pin offered to branches
   input wire logic        branch_pin_level, // Pin level for branches
   input wire logic        cpu_irq_req,      // Request to core
   input wire logic        global_mask,      // Global mask
   input wire logic        stack_push,       // Stack pulse
   input wire logic [2:0]  stack_item,       // Register stacked
   input wire logic        vec_rd,           // Vector fetch pulse
   input wire logic [15:0] vec_addr,         // Vector byte address
   input wire logic        vec_taken,        // Entry complete
   input wire logic [4:0]  vec_num           // Vector serviced
);
   // ==========================================================
   // One domain, so clock and reset given once
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_irq_unmasked: assert property (cpu_irq_req |-> !global_mask)
      else $error("request raised while masked");
   a_stack_order: assert property (stack_push && stack_item == EPIV_STK_PCL |=>
      stack_push && stack_item == EPIV_STK_PCH ##1 stack_push && stack_item == EPIV_STK_X
      ##1 stack_push && stack_item == EPIV_STK_A ##1 stack_push && stack_item == EPIV_STK_CCR)
      else $error("stack order wrong");
   a_mask_on_entry: assert property (stack_push && stack_item == EPIV_STK_CCR |=>
      global_mask [*3])
      else $error("mask not set on entry");
   a_fetch_after: assert property (stack_push && stack_item == EPIV_STK_CCR |=>
      vec_rd ##1 vec_rd ##1 vec_taken)
      else $error("vector fetch not after stacking");
   a_vec_pair: assert property (vec_rd && !vec_addr[0] |=>
      vec_rd && vec_addr == $past(vec_addr) + 16'h0001)
      else $error("low byte not at next address");
   a_vec_table: assert property (vec_taken |->
      $past(vec_addr) == EPIV_VEC_TOP_ADDR - {10'h000, vec_num, 1'b0} + 16'h0001)
      else $error("vector address off table");
   a_branch_gate: assert property (!branch_pin_valid |-> !branch_pin_level)
      else $error("pin level shown while unconfigured");
   a_wake_stop: assert property (wake_async |-> stop_mode && branch_pin_valid)
      else $error("wake outside stop or disabled");
   a_pull_gate: assert property (pull_enable |-> branch_pin_valid)
      else $error("pull on with pin disabled");
endmodule

bind epiv_top epiv_top_properties u_props (.*);
`default_nettype wire

// ---- bench/epiv_top_tb_top.sv ----
// Self-checking bench for the pin interrupt and vector block
`timescale 1ns/1ps
`default_nettype none
module epiv_top_tb_top;
   import epiv_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_pin, stop_mode, slow;
   logic wake_async, pull_enable, pull_up, branch_pin_valid, branch_pin_level;
   logic cpu_insn_done, cpu_mask_load, cpu_mask_value, cpu_irq_req, global_mask;
   logic stack_push, vec_rd, vec_taken, slverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, src_event, rdata, ev, expv, base;
   logic [15:0] vec_addr;
   logic [4:0]  vec_num;
   logic [2:0]  stack_item;
   logic        pol, mode;
   int          n_fail, n_checks;

   // Bench nets carry the port names, so every pin joins by name
   epiv_top u_epiv_top (.*);
   epiv_cpu_model u_epiv_cpu_model (.*);

   // ==========================================================
   // Clock, watchdog and shared tasks
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial
   begin
      #200000;
      n_fail++;
      print_verdict();
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata   = prdata;
      slverr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask
   function automatic logic [4:0] lowest(input logic [31:0] v);
      lowest = 5'h00;
      for (int k = 31; k >= 0; k--) if (v[k]) lowest = 5'(k);
   endfunction
   task automatic print_verdict();
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, src_event, stop_mode, slow} = '0;
      ext_pin = 1'b1;
      presetn = 1'b0;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(32'h7e2d4312));
      tick(5);
      presetn <= 1'b1;
      apb(1'b0, EPIV_OFS_PIN_CTL, '0);
      chk(rdata, 32'h0000_0000);
      apb(1'b0, EPIV_OFS_CORE_CTL, '0);
      chk(rdata, 32'h0000_0001);
      apb(1'b0, 8'h20, '0);
      chk(32'(slverr), 32'h0000_0001);
      ext_pin <= 1'b0;
      tick(8);
      ext_pin <= 1'b1;
      tick(8);
      apb(1'b0, EPIV_OFS_PIN_CTL, '0);
      chk(32'(rdata[EPIV_BIT_FLAG]), 32'h0000_0000);
      // Every polarity and detection mode
      for (int i = 0; i < 4; i++)
      begin
         {pol, mode} = 2'(i);
         base = 32'h0000_0010 | {26'h0, pol, 4'h0, mode};
         ext_pin <= ~pol;
         tick(8);
         apb(1'b1, EPIV_OFS_PIN_CTL, base);
         tick(2);
         apb(1'b0, EPIV_OFS_PIN_CTL, '0);
         chk(32'(rdata[EPIV_BIT_FLAG]), 32'h0000_0001);
         chk(32'({pull_enable, pull_up}), 32'({1'b1, ~pol}));
         apb(1'b1, EPIV_OFS_PIN_CTL, base | 32'h0000_0004);
         tick(6); // spacing after clear
         apb(1'b0, EPIV_OFS_PIN_CTL, '0);
         chk(32'(rdata[EPIV_BIT_FLAG]), 32'h0000_0000);
         ext_pin <= pol;
         tick(8);
         apb(1'b0, EPIV_OFS_PIN_CTL, '0);
         chk(32'(rdata[EPIV_BIT_FLAG]), 32'h0000_0001);
         chk(32'(branch_pin_level), 32'(pol));
         @(posedge pclk) stop_mode <= 1'b1;
         @(posedge pclk) chk(32'(wake_async), 32'h0000_0001);
         stop_mode <= 1'b0;
         apb(1'b1, EPIV_OFS_PIN_CTL, base | 32'h0000_0004);
         apb(1'b0, EPIV_OFS_PIN_CTL, '0);
         chk(32'(rdata[EPIV_BIT_FLAG]), 32'(mode));
         ext_pin <= ~pol;
         tick(8);
         // Function off again so the next enable is a fresh rising edge
         apb(1'b1, EPIV_OFS_PIN_CTL, base ^ 32'h0000_0054);
         apb(1'b0, EPIV_OFS_PIN_CTL, '0);
         chk(32'({rdata[EPIV_BIT_FLAG], pull_enable}), 32'h0000_0000);
      end
      // Random source set, flags first, then service in priority order
      ext_pin <= 1'b1;
      apb(1'b1, EPIV_OFS_PIN_CTL, 32'h0000_0010);
      ev = $urandom & EPIV_VEC_USED & ~32'h0000_0004;
      @(posedge pclk) src_event <= ev;
      @(posedge pclk) src_event <= '0;
      apb(1'b0, EPIV_OFS_SRC_FLAG, '0);
      chk(rdata, ev | 32'h0000_0004);
      chk(32'(cpu_irq_req), 32'h0000_0000);
      apb(1'b1, EPIV_OFS_SRC_EN, EPIV_VEC_USED);
      apb(1'b1, EPIV_OFS_PIN_CTL, 32'h0000_0012);
      apb(1'b1, EPIV_OFS_CORE_CTL, '0);
      expv = ev | 32'h0000_0004;
      while (expv != '0)
      begin
         slow <= 1'($urandom);
         while (vec_taken !== 1'b1) @(posedge pclk);
         chk(32'(vec_num), 32'(lowest(expv)));
         chk(32'(global_mask), 32'h0000_0001);
         if (lowest(expv) == EPIV_VEC_PIN) apb(1'b1, EPIV_OFS_PIN_CTL, 32'h0000_0016);
         else apb(1'b1, EPIV_OFS_SRC_FLAG, 32'h0000_0001 << lowest(expv));
         expv &= ~(32'h0000_0001 << lowest(expv));
      end
      tick(50);
      apb(1'b0, EPIV_OFS_VEC_STAT, '0);
      chk(32'(rdata[EPIV_BIT_ANY_PEND]), 32'h0000_0000);
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- inc/epiv_pin_if.sv ----
// Signals between the register core and the pin detector
`timescale 1ns/1ps
`default_nettype none
interface epiv_pin_if;
   logic fn_enable;   // Pin acts as interrupt input
   logic polarity;    // 1: rising and high, 0: falling and low
   logic level_mode;  // 1: edge and level, 0: edge only
   logic ack;         // Software clear pulse
   logic flag;        // Event flag
   logic pin_level;   // Filtered pin level
   logic asserted;    // Filtered pin at asserted level

   modport ctl (output fn_enable, polarity, level_mode, ack,
                input  flag, pin_level, asserted);
   modport det (input  fn_enable, polarity, level_mode, ack,
                output flag, pin_level, asserted);
endinterface
`default_nettype wire

// ---- inc/epiv_pkg.sv ----
// Constants shared by the external pin interrupt and vectoring block
package epiv_pkg;
   // ==========================================================
   // Register byte offsets on the APB
   localparam logic [7:0] EPIV_OFS_PIN_CTL  = 8'h00; // ext_pin_status_control
   localparam logic [7:0] EPIV_OFS_SRC_FLAG = 8'h04; // Source flags, write 1 clears
   localparam logic [7:0] EPIV_OFS_SRC_EN   = 8'h08; // Source local enables
   localparam logic [7:0] EPIV_OFS_CORE_CTL = 8'h0C; // Global mask
   localparam logic [7:0] EPIV_OFS_VEC_STAT = 8'h10; // Pending vector status

   // ==========================================================
   // Field positions in ext_pin_status_control
   localparam int EPIV_BIT_LEVEL_MODE = 0;
   localparam int EPIV_BIT_INT_EN     = 1;
   localparam int EPIV_BIT_ACK        = 2;
   localparam int EPIV_BIT_FLAG       = 3;
   localparam int EPIV_BIT_FN_EN      = 4;
   localparam int EPIV_BIT_POLARITY   = 5;
   localparam int EPIV_BIT_PULL_DIS   = 6;
   // Other fields
   localparam int EPIV_BIT_GMASK      = 0;
   localparam int EPIV_BIT_ANY_PEND   = 8;
   localparam int EPIV_BIT_VADDR_LO   = 16;

   // ==========================================================
   // Reset values
   localparam logic [6:0]  EPIV_RST_PIN_CTL = 7'h00;
   localparam logic [31:0] EPIV_RST_SRC_EN  = 32'h0000_0000;
   localparam logic        EPIV_RST_GMASK   = 1'b1;

   // ==========================================================
   // Vector table
   localparam int          EPIV_NUM_VEC      = 32;
   localparam logic [4:0]  EPIV_VEC_PIN      = 5'h02;
   localparam logic [15:0] EPIV_VEC_TOP_ADDR = 16'hFFFE;
   // Maskable vectors in use: 2..8, 11..28
   localparam logic [31:0] EPIV_VEC_USED     = 32'h1FFF_F9FC;

   // ==========================================================
   // Stacked items, in push order
   localparam logic [2:0] EPIV_STK_PCL = 3'h0;
   localparam logic [2:0] EPIV_STK_PCH = 3'h1;
   localparam logic [2:0] EPIV_STK_X   = 3'h2;
   localparam logic [2:0] EPIV_STK_A   = 3'h3;
   localparam logic [2:0] EPIV_STK_CCR = 3'h4;

   // Interrupt entry sequencer
   typedef enum logic [2:0] {
      EPIV_IDLE,
      EPIV_WAIT_INSN,
      EPIV_STACK,
      EPIV_FETCH_HI,
      EPIV_FETCH_LO,
      EPIV_DONE
   } epiv_state_t;
endpackage

// ---- verilog/epiv_pin_detect.sv ----
// External request pin synchroniser, event detector and wake path
`timescale 1ns/1ps
`default_nettype none
module epiv_pin_detect
   import epiv_pkg::*;
(
   input  wire logic   pclk,       // Bus clock
   input  wire logic   presetn,    // Async reset, active low
   input  wire logic   pin_in,     // Raw external request pin
   input  wire logic   stop_mode,  // Clocks are stopped
   output logic        wake_async, // Asynchronous wake request
   epiv_pin_if.det     pif         // Core side
);
   logic sync1;
   logic sync2;
   logic sync3;
   logic level;
   logic prev_asserted;
   logic fn_enable_d;
   logic flag;
   logic asserted;
   logic edge_seen;
   logic enable_rise;
   logic hold_level;

   // ==========================================================
   // Input filtering
   // [R08] Three flops on bus clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end
      else
      begin
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // [R20] Level accepted once stages agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level <= 1'b0;
      else if (sync2 == sync3)
         level <= sync3;
   end

   // ==========================================================
   // Event detection
   // [R02] Polarity picks the asserted level
   assign asserted    = pif.polarity ? level : ~level;
   // [R12] Deasserted to asserted transition
   assign edge_seen   = pif.fn_enable & asserted & ~prev_asserted;
   // [R10] Turning the pin on flags an event
   assign enable_rise = pif.fn_enable & ~fn_enable_d;
   // [R03] Level term only in edge and level mode
   assign hold_level  = pif.fn_enable & pif.level_mode & asserted;

   // History for edge and enable detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_asserted <= 1'b0;
         fn_enable_d   <= 1'b0;
      end
      else
      begin
         prev_asserted <= asserted;
         fn_enable_d   <= pif.fn_enable;
      end
   end

   // Flag: any set beats the clear in the same cycle
   // [R13] Clear ignored while pin asserted in edge and level mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag <= 1'b0;
      else if (edge_seen || enable_rise || hold_level)
         flag <= 1'b1;
      // [R21] Acknowledge write clears
      else if (pif.ack)
         flag <= 1'b0;
   end

   assign pif.flag      = flag;
   assign pif.pin_level = level;
   assign pif.asserted  = asserted;

   // [R09] Clockless wake path, raw pin gated by enable
   assign wake_async = stop_mode & pif.fn_enable & ~(pin_in ^ pif.polarity);
endmodule
`default_nettype wire

// ---- verilog/epiv_top.sv ----
// External pin interrupt, source flags and vector sequencer with APB slave
// Operation
// [R01] Pin raises events only while the function enable bit is 1.
// [R02] Polarity bit picks falling/low or rising/high as asserted.
// [R03] Mode bit picks edge-only or edge-and-level detection.
// [R04] Pin events always set the flag; request only with pin enable.
// [R05] Enabled pin with pull-disable 0 gets pull-up or pull-down by polarity.
// [R06] Pull-disable 1 switches the internal pull off.
// [R07] Pin level is offered to branch instructions while configured.
// [R08] Running clocks: synchronous detection on bus clock.
// [R09] Stop mode: asynchronous path lets enabled pin wake the part.
// [R10] Enabling the pin function sets the event flag.
// [R11] Software waits six cycles between flag clear and enable.
// [R12] Edge-and-level mode: deasserted-to-asserted move sets the flag.
// [R13] Edge-and-level mode: flag held set while pin stays asserted.
// [R14] Vector is two bytes, high byte at the lower address.
// [R15] Any condition sets its flag; request only if local enable is 1.
// [R16] Mask 0: finish instruction, stack five registers, set mask.
// [R17] After stacking, fetch vector of lowest-numbered pending source.
// [R18] Fixed descending two-byte table; vector 28 at FFC6/FFC7.
// [R19] Reset sets the global mask.
// [R20] Pin passes synchroniser before edge compare, one flag per edge.
// [R21] Acknowledge write clears the flag except while level holds.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module epiv_top
   import epiv_pkg::*;
(
   input  wire logic        pclk,            // Bus clock, 250 MHz
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB access phase
   input  wire logic        pwrite,          // APB direction
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic [31:0]      prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error
   input  wire logic        ext_pin,         // External request pin
   input  wire logic        stop_mode,       // Clocks shut down
   output logic             wake_async,      // Stop mode wake request
   output logic             pull_enable,     // Internal pull on
   output logic             pull_up,         // 1 pull-up, 0 pull-down
   output logic             branch_pin_valid,// Pin level usable by branches
   output logic             branch_pin_level,// Pin level for branches
   input  wire logic [31:0] src_event,       // Peripheral event pulses
   input  wire logic        cpu_insn_done,   // Instruction boundary pulse
   input  wire logic        cpu_mask_load,   // Mask restore pulse
   input  wire logic        cpu_mask_value,  // Mask value restored
   output logic             cpu_irq_req,     // Qualified request level
   output logic             global_mask,     // Global interrupt mask
   output logic             stack_push,      // Stack one register pulse
   output logic [2:0]       stack_item,      // Register being stacked
   output logic             vec_rd,          // Vector byte fetch pulse
   output logic [15:0]      vec_addr,        // Vector byte address
   output logic             vec_taken,       // Entry complete pulse
   output logic [4:0]       vec_num          // Vector being serviced
);
   epiv_pin_if pif ();

   logic        level_mode;
   logic        int_enable;
   logic        fn_enable;
   logic        polarity;
   logic        pull_disable;
   logic        ack_pulse;
   logic [31:0] src_flag;
   logic [31:0] src_enable;
   logic [31:0] pending;
   logic [31:0] qualified;
   logic [4:0]  best_vec;
   logic        any_req;
   logic        any_pend;
   logic [4:0]  pend_vec;
   epiv_state_t state;
   logic [2:0]  stk_cnt;
   logic [4:0]  cur_vec;
   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic [31:0] next_prdata;

   // ==========================================================
   // Helper functions
   // Lowest set bit wins, vector 0 is highest priority
   function automatic logic [5:0] first_set(input logic [31:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = EPIV_NUM_VEC - 1; i >= 0; i--)
      begin
         if (v[i])
            r = {1'b1, 5'(i)};
      end
      return r;
   endfunction

   // [R18] Descending table, two bytes each
   function automatic logic [15:0] vec_hi_addr(input logic [4:0] n);
      return EPIV_VEC_TOP_ADDR - {10'h000, n, 1'b0};
   endfunction

   // Decode of the four writable and one read-only register
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == EPIV_OFS_PIN_CTL) || (a == EPIV_OFS_SRC_FLAG)
          || (a == EPIV_OFS_SRC_EN) || (a == EPIV_OFS_CORE_CTL)
          || (a == EPIV_OFS_VEC_STAT);
   endfunction

   // ==========================================================
   // APB slave: zero wait states
   assign pready   = 1'b1;
   assign mapped   = is_mapped(paddr);
   assign pslverr  = psel & penable & ~mapped;
   assign wr_acc   = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;

   // Pin control register fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         level_mode   <= EPIV_RST_PIN_CTL[EPIV_BIT_LEVEL_MODE];
         int_enable   <= EPIV_RST_PIN_CTL[EPIV_BIT_INT_EN];
         fn_enable    <= EPIV_RST_PIN_CTL[EPIV_BIT_FN_EN];
         polarity     <= EPIV_RST_PIN_CTL[EPIV_BIT_POLARITY];
         pull_disable <= EPIV_RST_PIN_CTL[EPIV_BIT_PULL_DIS];
      end
      else if (wr_acc && paddr == EPIV_OFS_PIN_CTL)
      begin
         level_mode   <= pwdata[EPIV_BIT_LEVEL_MODE];
         int_enable   <= pwdata[EPIV_BIT_INT_EN];
         fn_enable    <= pwdata[EPIV_BIT_FN_EN];
         polarity     <= pwdata[EPIV_BIT_POLARITY];
         pull_disable <= pwdata[EPIV_BIT_PULL_DIS];
      end
   end

   // [R21] Acknowledge bit is a write-only strobe
   assign ack_pulse = wr_acc && (paddr == EPIV_OFS_PIN_CTL) && pwdata[EPIV_BIT_ACK];

   // Local enables; pin enable lives in the pin register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         src_enable <= EPIV_RST_SRC_EN;
      else if (wr_acc && paddr == EPIV_OFS_SRC_EN)
         src_enable <= pwdata & EPIV_VEC_USED;
   end

   // [R15] Events set flags; a set beats a write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         src_flag <= 32'h0000_0000;
      else if (wr_acc && paddr == EPIV_OFS_SRC_FLAG)
         src_flag <= ((src_flag & ~pwdata) | src_event) & EPIV_VEC_USED;
      else
         src_flag <= (src_flag | src_event) & EPIV_VEC_USED;
   end

   // ==========================================================
   // Pin detector
   // [R01] Only the enable bit turns the pin into a request input
   assign pif.fn_enable  = fn_enable;
   assign pif.polarity   = polarity;
   assign pif.level_mode = level_mode;
   assign pif.ack        = ack_pulse;

   epiv_pin_detect u_pin
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_in     (ext_pin),
      .stop_mode  (stop_mode),
      .wake_async (wake_async),
      .pif        (pif)
   );

   // [R05] Pull follows polarity: pull-up for falling and low
   // [R06] Pull-disable turns it off for an external resistor
   assign pull_enable = fn_enable & ~pull_disable;
   assign pull_up     = ~polarity;

   // [R07] Filtered level, valid while the pin is configured
   assign branch_pin_valid = fn_enable;
   assign branch_pin_level = fn_enable & pif.pin_level;

   // ==========================================================
   // Priority resolution
   // [R04] Pin flag always visible; request needs the pin enable
   always_comb
   begin
      pending               = src_flag;
      pending[EPIV_VEC_PIN] = pif.flag;
      qualified             = pending & src_enable;
      qualified[EPIV_VEC_PIN] = pif.flag & int_enable;
   end

   // [R17] Lowest vector number among qualified sources
   assign {any_req, best_vec}   = first_set(qualified);
   assign {any_pend, pend_vec}  = first_set(pending);

   // [R16] Request only reaches the sequencer with mask clear
   assign cpu_irq_req = any_req & ~global_mask;

   // ==========================================================
   // Global mask
   // [R19] Reset masks all sources
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         global_mask <= EPIV_RST_GMASK;
      else if (state == EPIV_STACK && stk_cnt == EPIV_STK_CCR)
         global_mask <= 1'b1;
      else if (cpu_mask_load)
         global_mask <= cpu_mask_value;
      else if (wr_acc && paddr == EPIV_OFS_CORE_CTL)
         global_mask <= pwdata[EPIV_BIT_GMASK];
   end

   // ==========================================================
   // Interrupt entry sequencer
   // [R16] Wait for boundary, stack PROG_COUNTER_LOW PROG_COUNTER_HIGH X A CONDITION_CODE_REG, then fetch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state   <= EPIV_IDLE;
         stk_cnt <= EPIV_STK_PCL;
         cur_vec <= 5'h00;
      end
      else
      begin
         case (state)
            EPIV_IDLE:
            begin
               if (cpu_irq_req)
                  state <= EPIV_WAIT_INSN;
            end
            EPIV_WAIT_INSN:
            begin
               // Request withdrawn before the boundary is dropped
               if (!cpu_irq_req)
                  state <= EPIV_IDLE;
               else if (cpu_insn_done)
               begin
                  state   <= EPIV_STACK;
                  stk_cnt <= EPIV_STK_PCL;
                  cur_vec <= best_vec;
               end
            end
            EPIV_STACK:
            begin
               if (stk_cnt == EPIV_STK_CCR)
               begin
                  state <= EPIV_FETCH_HI;
                  // [R17] Re-resolve after stacking if still pending
                  if (any_req)
                     cur_vec <= best_vec;
               end
               else
                  stk_cnt <= stk_cnt + 3'h1;
            end
            EPIV_FETCH_HI:
               state <= EPIV_FETCH_LO;
            EPIV_FETCH_LO:
               state <= EPIV_DONE;
            EPIV_DONE:
               state <= EPIV_IDLE;
            default:
               state <= EPIV_IDLE;
         endcase
      end
   end

   // Sequencer outputs, registered so they are glitch free
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stack_push <= 1'b0;
         stack_item <= EPIV_STK_PCL;
         vec_rd     <= 1'b0;
         vec_addr   <= 16'h0000;
         vec_taken  <= 1'b0;
         vec_num    <= 5'h00;
      end
      else
      begin
         stack_push <= (state == EPIV_STACK);
         stack_item <= stk_cnt;
         vec_rd     <= (state == EPIV_FETCH_HI) || (state == EPIV_FETCH_LO);
         vec_taken  <= (state == EPIV_DONE);
         vec_num    <= cur_vec;
         // [R14] High byte first at the lower address, then low byte
         if (state == EPIV_FETCH_HI)
            vec_addr <= vec_hi_addr(cur_vec);
         else if (state == EPIV_FETCH_LO)
            vec_addr <= vec_hi_addr(cur_vec) + 16'h0001;
      end
   end

   // ==========================================================
   // Read data, captured in the setup phase
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         EPIV_OFS_PIN_CTL:
         begin
            next_prdata[EPIV_BIT_LEVEL_MODE] = level_mode;
            next_prdata[EPIV_BIT_INT_EN]     = int_enable;
            next_prdata[EPIV_BIT_FLAG]       = pif.flag;
            next_prdata[EPIV_BIT_FN_EN]      = fn_enable;
            next_prdata[EPIV_BIT_POLARITY]   = polarity;
            next_prdata[EPIV_BIT_PULL_DIS]   = pull_disable;
         end
         EPIV_OFS_SRC_FLAG:
            next_prdata = pending;
         EPIV_OFS_SRC_EN:
            next_prdata = src_enable;
         EPIV_OFS_CORE_CTL:
            next_prdata[EPIV_BIT_GMASK] = global_mask;
         EPIV_OFS_VEC_STAT:
         begin
            next_prdata[4:0]              = pend_vec;
            next_prdata[EPIV_BIT_ANY_PEND] = any_pend;
            next_prdata[31:EPIV_BIT_VADDR_LO] = vec_hi_addr(pend_vec);
         end
         default:
            next_prdata = 32'h0000_0000;
      endcase
   end

   // Capturing early keeps prdata off a combinational path
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= next_prdata;
   end
endmodule
`default_nettype wire
